//--- rtl/mobp_port.sv
// Output buffer and 21-byte message talker for the bus
`timescale 1ns/100ps
module mobp_port
  import mobp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  // Mode and addressing
  input  wire logic        talk_only,
  input  wire logic        addr_talk,
  input  wire logic        addr_listen,
  input  wire logic        hold_mode,
  input  wire logic        reset_key,
  // Measurement engine
  input  wire logic        cycle_done,
  input  wire logic [15:0] func_letters,
  input  wire logic        value_neg,
  input  wire logic [43:0] value_bcd,
  input  wire logic [3:0]  point_pos,
  input  wire logic        exp_neg,
  input  wire logic [7:0]  exp_bcd,
  output logic             cycle_start,
  output logic             rate_hold,
  // Command gate
  input  wire logic        cmd_valid,
  output logic             cmd_accept,
  // Talker handshake
  output logic             talk_valid,
  input  wire logic        talk_ready,
  output logic [7:0]       talk_data,
  output logic             talk_eoi,
  output logic             buffer_full,
  output logic             dropped
);
  logic [15:0] buf_letters;
  logic        buf_neg;
  logic [43:0] buf_bcd;
  logic [3:0]  buf_point;
  logic        buf_eneg;
  logic [7:0]  buf_exp;
  logic [15:0] pend_letters;
  logic        pend_neg;
  logic [43:0] pend_bcd;
  logic [3:0]  pend_point;
  logic        pend_eneg;
  logic [7:0]  pend_exp;
  logic        pending;
  logic        in_progress;
  logic        talk_enabled;
  logic        load_now;
  logic [4:0]  idx;
  logic [7:0]  next_byte;
  logic        fifo_in_ready;
  logic        fifo_empty;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_push;
  logic        lf_taken;
  logic [4:0]  sent_cnt;
  mobp_state_t state;

  // Talking allowed by talk-only or by being addressed
  assign talk_enabled = talk_only || addr_talk;
  // Load on cycle end, deferred while a message is on its way
  assign load_now  = (cycle_done || pending) && !in_progress;
  assign cmd_accept = cmd_valid && !talk_only && addr_listen;
  assign cycle_start = hold_mode && reset_key;
  assign rate_hold   = hold_mode;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending <= 1'b0;
    end else if (enable) begin
      if (load_now) pending <= 1'b0;
      else if (cycle_done) pending <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buf_letters <= 16'h0000;
      buf_neg     <= 1'b0;
      buf_bcd     <= '0;
      buf_point   <= 4'h0;
      buf_eneg    <= 1'b0;
      buf_exp     <= 8'h00;
      dropped     <= 1'b0;
    end else if (enable) begin
      dropped <= 1'b0;
      if (cycle_done && !in_progress) begin
        buf_letters <= func_letters;
        buf_neg     <= value_neg;
        buf_bcd     <= value_bcd;
        buf_point   <= point_pos;
        buf_eneg    <= exp_neg;
        buf_exp     <= exp_bcd;
        dropped     <= buffer_full || pending;
      end else if (cycle_done) begin
        dropped     <= pending;
      end else if (pending && !in_progress) begin
        buf_letters <= pend_letters;
        buf_neg     <= pend_neg;
        buf_bcd     <= pend_bcd;
        buf_point   <= pend_point;
        buf_eneg    <= pend_eneg;
        buf_exp     <= pend_exp;
      end
    end
  end

  // Result parked while a message is on its way
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_letters <= 16'h0000;
      pend_neg     <= 1'b0;
      pend_bcd     <= 44'h00000000000;
      pend_point   <= 4'h0;
      pend_eneg    <= 1'b0;
      pend_exp     <= 8'h00;
    end else if (enable && cycle_done && in_progress) begin
      pend_letters <= func_letters;
      pend_neg     <= value_neg;
      pend_bcd     <= value_bcd;
      pend_point   <= point_pos;
      pend_eneg    <= exp_neg;
      pend_exp     <= exp_bcd;
    end
  end

  // Full flag: set wins over the clear at end of message
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buffer_full <= 1'b0;
    end else if (enable) begin
      if (load_now) buffer_full <= 1'b1;
      else if (lf_taken) buffer_full <= 1'b0;
    end
  end

  // Byte builder for the fixed message layout
  always_comb begin
    next_byte = CH_ZERO;
    if (idx == 5'h00) begin
      next_byte = buf_letters[15:8];
    end else if (idx == 5'h01) begin
      next_byte = buf_letters[7:0];
    end else if (idx == 5'h02) begin
      next_byte = buf_neg ? CH_MINUS : CH_PLUS;
    end else if (idx <= 5'h0E) begin
      // Positions 3..14: 11 digits with a point after digit point_pos
      if (idx - 5'h03 == {1'b0, buf_point}) begin
        next_byte = CH_DOT;
      end else if (idx - 5'h03 < {1'b0, buf_point}) begin
        next_byte = CH_ZERO | {4'h0, buf_bcd[43 - 4*(idx - 5'h03) -: 4]};
      end else begin
        next_byte = CH_ZERO | {4'h0, buf_bcd[43 - 4*(idx - 5'h04) -: 4]};
      end
    end else if (idx == 5'h0F) begin
      next_byte = CH_EXP;
    end else if (idx == 5'h10) begin
      next_byte = buf_eneg ? CH_MINUS : CH_PLUS;
    end else if (idx == 5'h11) begin
      next_byte = CH_ZERO | {4'h0, buf_exp[7:4]};
    end else if (idx == 5'h12) begin
      next_byte = CH_ZERO | {4'h0, buf_exp[3:0]};
    end else if (idx == 5'h13) begin
      next_byte = CH_CR;
    end else begin
      next_byte = CH_LF;
    end
  end

  assign fifo_push = (state == MOBP_SEND) && fifo_in_ready;

  // Sequencer: starts only on a full buffer and an enabled talker
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state       <= MOBP_IDLE;
      idx         <= 5'h00;
      in_progress <= 1'b0;
    end else if (enable) begin
      unique case (state)
        MOBP_IDLE: begin
          if (buffer_full && !load_now && talk_enabled) begin
            state       <= MOBP_SEND;
            idx         <= 5'h00;
            in_progress <= 1'b1;
          end
        end
        MOBP_SEND: begin
          if (fifo_push) begin
            if (idx == LAST_IDX) state <= MOBP_DRAIN;
            else idx <= idx + 5'h01;
          end
        end
        MOBP_DRAIN: begin
          if (lf_taken) begin
            state       <= MOBP_IDLE;
            in_progress <= 1'b0;
          end
        end
      endcase
    end
  end

  mobp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .enable    (enable),
    .flush     (1'b0),
    .in_valid  (state == MOBP_SEND),
    .in_ready  (fifo_in_ready),
    .in_data   (next_byte),
    .out_valid (fifo_out_valid),
    .out_ready (talk_ready && talk_enabled),
    .out_data  (fifo_out_data),
    .empty     (fifo_empty)
  );

  // Empty buffer means no valid byte: handshake stalls
  assign talk_valid = fifo_out_valid && talk_enabled;
  assign talk_data  = fifo_out_data;
  assign talk_eoi   = talk_valid && (fifo_out_data == CH_LF) && (sent_cnt == LAST_IDX);
  assign lf_taken   = talk_eoi && talk_ready;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sent_cnt <= 5'h00;
    end else if (enable && talk_valid && talk_ready) begin
      sent_cnt <= (sent_cnt == LAST_IDX) ? 5'h00 : sent_cnt + 5'h01;
    end
  end

  message_length_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && talk_valid && talk_ready && sent_cnt == LAST_IDX) |-> talk_data == CH_LF)
    else $error("byte 21 of a message is not LF");
  empty_after_lf_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && lf_taken && !load_now) |=> !buffer_full)
    else $error("buffer not emptied after message");
  stall_empty_a: assert property (@(posedge clock) disable iff (!resetn)
    !in_progress |-> !talk_valid)
    else $error("byte offered from empty buffer");
  defer_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && cycle_done && in_progress) |=> $stable(buf_bcd))
    else $error("buffer changed during transfer");
  deferred_done_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && cycle_done && in_progress) |=> pending || buffer_full)
    else $error("deferred result lost");
  overwrite_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && cycle_done && !in_progress) |=> buf_bcd == $past(value_bcd))
    else $error("buffer not overwritten");
  listen_only_a: assert property (@(posedge clock) disable iff (!resetn)
    cmd_accept |-> (addr_listen && !talk_only))
    else $error("command accepted while not listener");
  start_full_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == MOBP_IDLE ##1 state == MOBP_SEND) |-> $past(buffer_full))
    else $error("message started from empty buffer");
  deferred_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && pending && !in_progress && !cycle_done) |=> buf_bcd == $past(pend_bcd))
    else $error("deferred result not loaded");
  pend_full_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && pending && !in_progress && !cycle_done) |=> buffer_full)
    else $error("deferred load did not fill buffer");
  talk_only_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && talk_only && cycle_done && !in_progress) |=> buffer_full)
    else $error("talk-only cycle end did not load");
  overwrite_drop_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && cycle_done && !in_progress && buffer_full) |=> dropped)
    else $error("overwrite not flagged");
  byte_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && talk_valid && !talk_ready) |=> !talk_enabled || (talk_valid && $stable(talk_data)))
    else $error("offered byte withdrawn before taken");
  wait_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && state == MOBP_IDLE && load_now) |=> state == MOBP_IDLE)
    else $error("message started during a load");
  lf_done_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && lf_taken) |=> !in_progress)
    else $error("transfer not closed after LF");
  talk_off_a: assert property (@(posedge clock) disable iff (!resetn)
    (!talk_only && !addr_talk) |-> !talk_valid)
    else $error("byte offered while not talker");
  full_stays_a: assert property (@(posedge clock) disable iff (!resetn)
    (enable && buffer_full && !lf_taken) |=> buffer_full)
    else $error("buffer emptied before message end");
endmodule

//--- shared/mobp_pkg.sv
// Shared constants for the measurement output buffer port
package mobp_pkg;
  localparam int MSG_LEN    = 21;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  localparam int DIGITS     = 11;
  localparam int DP_MAX     = 11;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_EXP   = 8'h45;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [4:0] LAST_IDX = 5'h14;
  typedef enum logic [1:0] {MOBP_IDLE, MOBP_SEND, MOBP_DRAIN} mobp_state_t;
endpackage

//--- rtl/mobp_fifo.sv
// Byte FIFO between the message sequencer and the bus talker
`timescale 1ns/100ps
module mobp_fifo
  import mobp_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             enable,
  input  wire logic             flush,
  // Write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign empty     = (count == '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (enable && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (enable) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (push) wr_ptr <= wr_ptr + 1'b1;
        if (pop) rd_ptr <= rd_ptr + 1'b1;
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule

//--- sim/mobp_listener.sv
// Listener model that takes message bytes from the port
`timescale 1ns/100ps
module mobp_listener (
  // Clock and pacing
  input  wire logic       clock,
  input  wire logic       slow,
  // Talker side
  input  wire logic       talk_valid,
  input  wire logic [7:0] talk_data,
  input  wire logic       talk_eoi,
  output logic            talk_ready,
  // Captured bytes
  output logic [7:0]      got [0:63],
  output logic            got_eoi [0:63],
  output logic [7:0]      count
);
  initial begin
    talk_ready = 1'b0;
    count = 8'h00;
    forever begin
      @(posedge clock);
      if (talk_valid && talk_ready) begin
        got[count[5:0]] <= talk_data;
        got_eoi[count[5:0]] <= talk_eoi;
        count <= count + 8'h01;
      end
      talk_ready <= slow ? !talk_ready : 1'b1;
    end
  end
endmodule

//--- sim/measurement_output_buffer_port_tb.sv
// Self-checking bench for the measurement output buffer port
`timescale 1ns/100ps
module measurement_output_buffer_port_tb;
  import mobp_pkg::*;
  typedef struct packed {
    logic [15:0] f;
    logic        neg;
    logic [43:0] bcd;
    logic [3:0]  pp;
    logic        en;
    logic [7:0]  eb;
  } mobp_res_t;
  logic        clock = 0, resetn = 0, talk_only = 0, addr_talk = 0, addr_listen = 0, slow = 0;
  logic        hold_mode = 0, reset_key = 0, cycle_done = 0, cmd_valid = 0;
  logic        cycle_start, rate_hold, cmd_accept, talk_valid, talk_ready, talk_eoi, buffer_full, dropped;
  logic [7:0]  talk_data, count;
  logic [7:0]  got [0:63];
  logic        got_eoi [0:63];
  mobp_res_t   res = '0;
  int          failures = 0, tests_run = 0, drop_n = 0;
  localparam mobp_res_t RA = '{16'h4641, 1'b0, 44'h00012345678, 4'h5, 1'b0, 8'h03};
  localparam mobp_res_t RB = '{16'h5041, 1'b1, 44'h98765432109, 4'h0, 1'b1, 8'h06};
  localparam mobp_res_t RC = '{16'h5048, 1'b0, 44'h10000000001, 4'hB, 1'b1, 8'h12};

  mobp_port dut_u (.clock(clock), .resetn(resetn), .enable(1'b1), .talk_only(talk_only),
    .addr_talk(addr_talk), .addr_listen(addr_listen), .hold_mode(hold_mode), .reset_key(reset_key),
    .cycle_done(cycle_done), .func_letters(res.f), .value_neg(res.neg), .value_bcd(res.bcd),
    .point_pos(res.pp), .exp_neg(res.en), .exp_bcd(res.eb), .cycle_start(cycle_start),
    .rate_hold(rate_hold), .cmd_valid(cmd_valid), .cmd_accept(cmd_accept), .talk_valid(talk_valid),
    .talk_ready(talk_ready), .talk_data(talk_data), .talk_eoi(talk_eoi), .buffer_full(buffer_full),
    .dropped(dropped));
  mobp_listener lsn_u (.clock(clock), .slow(slow), .talk_valid(talk_valid), .talk_data(talk_data),
    .talk_eoi(talk_eoi), .talk_ready(talk_ready), .got(got), .got_eoi(got_eoi), .count(count));

  always #12.5 clock = ~clock;
  always @(posedge clock) if (dropped === 1'b1) drop_n++;

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic load(input mobp_res_t r);
    @(posedge clock);
    res <= r;
    cycle_done <= 1'b1;
    @(posedge clock);
    cycle_done <= 1'b0;
  endtask

  task automatic wait_n(input int n);
    for (int i = 0; i < 400 && count < n; i++) @(posedge clock);
    #1;
    check(count >= n, 1);
  endtask

  // Build the expected 21 bytes and compare with those captured from base on
  task automatic check_msg(input int base, input mobp_res_t r);
    logic [7:0] e [0:20];
    int k;
    wait_n(base + MSG_LEN);
    e[0] = r.f[15:8];
    e[1] = r.f[7:0];
    e[2] = r.neg ? CH_MINUS : CH_PLUS;
    k = 3;
    for (int d = 0; d < DIGITS; d++) begin
      if (d == r.pp) e[k++] = CH_DOT;
      e[k++] = CH_ZERO + r.bcd[43-4*d -: 4];
    end
    if (r.pp == DP_MAX) e[k++] = CH_DOT;
    e[15] = CH_EXP;
    e[16] = r.en ? CH_MINUS : CH_PLUS;
    e[17] = CH_ZERO + r.eb[7:4];
    e[18] = CH_ZERO + r.eb[3:0];
    e[19] = CH_CR;
    e[20] = CH_LF;
    for (int i = 0; i < MSG_LEN; i++) begin
      check(got[(base + i) % 64], e[i]);
      check(got_eoi[(base + i) % 64], i == MSG_LEN - 1);
    end
  endtask

  task automatic t_empty_stall;
    addr_talk <= 1'b1;
    repeat (10) begin
      @(posedge clock);
      #1;
      check(talk_valid, 0);
    end
    load(RA);
    check_msg(0, RA);
    @(posedge clock);
    #1;
    check(buffer_full, 0);
  endtask

  task automatic t_overwrite;
    int d0;
    d0 = drop_n;
    addr_talk <= 1'b0;
    load(RA);
    load(RB);
    repeat (2) @(posedge clock);
    #1;
    check(drop_n - d0, 1);
    check(buffer_full, 1);
    addr_talk <= 1'b1;
    check_msg(21, RB);
  endtask

  task automatic t_defer;
    slow <= 1'b1;
    load(RA);
    wait_n(45);
    load(RB);
    check_msg(42, RA);
    check_msg(63, RB);
    slow <= 1'b0;
  endtask

  task automatic t_modes;
    addr_talk <= 1'b0;
    talk_only <= 1'b1;
    addr_listen <= 1'b1;
    cmd_valid <= 1'b1;
    load(RC);
    #1;
    check(cmd_accept, 0);
    check_msg(84, RC);
    talk_only <= 1'b0;
    hold_mode <= 1'b1;
    reset_key <= 1'b1;
    @(posedge clock);
    #1;
    check(cmd_accept, 1);
    check({cycle_start, rate_hold}, 2'b11);
    addr_listen <= 1'b0;
    reset_key <= 1'b0;
    @(posedge clock);
    #1;
    check(cmd_accept, 0);
    check({cycle_start, rate_hold}, 2'b01);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    t_empty_stall();
    t_overwrite();
    t_defer();
    t_modes();
    stop_test();
  end

  initial begin
    #(25 * 5000);
    failures++;
    stop_test();
  end
endmodule
